// File: verilog/sra_cfg.svh
// register map, field positions and reset values of the sysref aligner
`ifndef SRA_CFG_SVH
`define SRA_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SRA_ADDR_DIV         16'h0108
`define SRA_ADDR_CTRL        16'h010a
`define SRA_ADDR_STAT        16'h010b
`define SRA_ADDR_DLY         16'h0110

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SRA_AUTO_BIT         7
`define SRA_NEG_HI           3
`define SRA_NEG_LO           2
`define SRA_POS_HI           1
`define SRA_POS_LO           0
`define SRA_STAT_HI          3
`define SRA_DLY_HI           2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SRA_CTRL_RST         8'h00
`define SRA_STAT_RST         4'h0
`define SRA_DLY_RST          3'h0

// ---------------------------------------------------------------
// timing: divider phase advances two half cycles per clock
// ---------------------------------------------------------------
`define SRA_PHASE_STEP       4'h2

`endif

// File: verilog/sra_pkg.sv
// types and shared decode for the sysref aligner
package sra_pkg;

   // clock delay mode field encodings
   typedef enum logic [2:0] {
      SRA_DLY_NONE    = 3'h0,
      SRA_DLY_FINE    = 3'h2,
      SRA_DLY_FINE_LJ = 3'h3
   } sra_dly_mode_t;

   typedef logic [3:0] sra_phase_t;

   // divider period in half input-clock cycles
   function automatic sra_phase_t sra_period_h(input logic [2:0] div_sel);
      sra_phase_t p;
      p = 4'h2;
      unique case (div_sel)
         3'h1:    p = 4'h4;
         3'h3:    p = 4'h8;
         default: p = 4'h2;
      endcase
      return p;
   endfunction : sra_period_h

endpackage : sra_pkg

// File: verilog/sra_phase_capture.sv
// divider phase counter, sysref capture and skew window filter
`timescale 1ns/1ns
`include "sra_cfg.svh"

module sra_phase_capture (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              sysref,
   input  wire logic              capt_en,
   input  wire logic              auto_en,
   input  wire logic [1:0]        neg_win,
   input  wire logic [1:0]        pos_win,
   input  wire logic [2:0]        div_sel,
   output sra_pkg::sra_phase_t    phase,
   output sra_pkg::sra_phase_t    capt_phase,
   output sra_pkg::sra_phase_t    status,
   output logic                   sref_evt,
   output logic                   in_win
);

   sra_pkg::sra_phase_t period_h;
   sra_pkg::sra_phase_t next_phase;
   sra_pkg::sra_phase_t applied;
   logic                sref_q;

   // ---------------------------------------------------------------
   // divider phase in half cycles
   // ---------------------------------------------------------------
   assign period_h = sra_pkg::sra_period_h(div_sel);

   always_comb begin
      if (phase + `SRA_PHASE_STEP >= period_h) begin
         next_phase = 4'h0;
      end else begin
         next_phase = phase + `SRA_PHASE_STEP;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 4'h0;
      end else begin
         phase <= next_phase;
      end
   end

   // ---------------------------------------------------------------
   // sysref rising edge, only while capture is enabled
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sref_q <= 1'b0;
      end else begin
         sref_q <= sysref;
      end
   end

   assign sref_evt = sysref & ~sref_q & capt_en;

   // ---------------------------------------------------------------
   // skew windows: a hit close to the edge counts as on the edge
   // ---------------------------------------------------------------
   always_comb begin
      in_win = (phase <= {2'h0, pos_win});                    // see RL5
      if (phase != 4'h0 && (period_h - phase) <= {2'h0, neg_win}) begin
         in_win = 1'b1;                                        // see RL2
      end
   end

   // zero windows only forgive phase 0, so status tracks capture in auto adjust mode
   assign applied = in_win ? 4'h0 : phase;                    // see RL8

   // raw captured phase, held until the next capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         capt_phase <= `SRA_STAT_RST;
      end else if (sref_evt) begin
         capt_phase <= phase;                                  // see RL10
      end
   end

   // applied phase status, only moves in auto adjust mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= `SRA_STAT_RST;
      end else if (sref_evt && auto_en) begin
         status <= applied;                                    // see RL6
      end
   end

endmodule : sra_phase_capture

// File: verilog/sra_align.sv
// sysref divider phase alignment control and status registers
`timescale 1ns/1ns
`include "sra_cfg.svh"

// Function
// RL1: auto mode offset is captured plus local
// RL2: ignore sysref inside negative skew window
// RL3: software disables sysref before changing windows
// RL4: negative window codes zero to three halves
// RL5: ignore sysref inside positive skew window
// RL6: windows act only with auto adjust set
// RL7: software keeps window sum below divider
// RL8: positive window zero means exact capture
// RL9: four bit status of applied phase
// RL10: zero windows: status equals captured phase
// RL11: delay mode none, fine, low jitter fine
// RL12: software limits fine steps to sixteen
module sra_align (
   input  wire logic           CLK,
   input  wire logic           RST_B,
   input  wire logic           REG_WE,
   input  wire logic           REG_RE,
   input  wire logic [15:0]    REG_ADDR,
   input  wire logic [7:0]     REG_WDATA,
   output logic      [7:0]     REG_RDATA,
   input  wire logic           SYSREF,
   input  wire logic [1:0]     SYSREF_MODE,
   input  wire logic [2:0]     DIV_SEL,
   input  wire logic [3:0]     LOCAL_PHASE,
   output logic      [3:0]     PHASE_OFFSET,
   output logic      [3:0]     CAPT_PHASE,
   output logic      [3:0]     DIV_PHASE,
   output logic                AUTO_ADJ_EN,
   output logic      [2:0]     DLY_MODE,
   output logic                DLY_FINE_EN,
   output logic                DLY_LOW_JITTER
);

   logic                auto_en;
   logic [1:0]          neg_win;
   logic [1:0]          pos_win;
   logic [2:0]          dly_mode;
   logic                capt_en;
   logic                sref_evt;
   logic                in_win;
   sra_pkg::sra_phase_t status;
   sra_pkg::sra_phase_t capt_phase;
   sra_pkg::sra_phase_t phase;
   sra_pkg::sra_phase_t next_offset;
   logic [7:0]          next_rdata;

   // ---------------------------------------------------------------
   // control register writes
   // ---------------------------------------------------------------
   // windows are taken as written; software must pause sysref first
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         auto_en <= 1'b0;
         neg_win <= 2'h0;
         pos_win <= 2'h0;
      end else if (REG_WE && REG_ADDR == `SRA_ADDR_CTRL) begin
         auto_en <= REG_WDATA[`SRA_AUTO_BIT];
         neg_win <= REG_WDATA[`SRA_NEG_HI:`SRA_NEG_LO];        // see RL4
         pos_win <= REG_WDATA[`SRA_POS_HI:`SRA_POS_LO];
      end
   end

   // delay mode kept as written; unlisted codes pass through
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         dly_mode <= `SRA_DLY_RST;
      end else if (REG_WE && REG_ADDR == `SRA_ADDR_DLY) begin
         dly_mode <= REG_WDATA[`SRA_DLY_HI:0];
      end
   end

   // ---------------------------------------------------------------
   // phase capture and skew filtering
   // ---------------------------------------------------------------
   assign capt_en = (SYSREF_MODE != 2'h0);

   sra_phase_capture u_capture (
      .clk        (CLK),
      .rst_b      (RST_B),
      .sysref     (SYSREF),
      .capt_en    (capt_en),
      .auto_en    (auto_en),
      .neg_win    (neg_win),
      .pos_win    (pos_win),
      .div_sel    (DIV_SEL),
      .phase      (phase),
      .capt_phase (capt_phase),
      .status     (status),
      .sref_evt   (sref_evt),
      .in_win     (in_win)
   );

   assign CAPT_PHASE = capt_phase;
   assign DIV_PHASE  = phase;

   // ---------------------------------------------------------------
   // effective divider phase offset
   // ---------------------------------------------------------------
   always_comb begin
      if (auto_en) begin
         next_offset = status + LOCAL_PHASE;                   // see RL1
      end else begin
         next_offset = LOCAL_PHASE;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PHASE_OFFSET <= 4'h0;
      end else begin
         PHASE_OFFSET <= next_offset;
      end
   end

   // ---------------------------------------------------------------
   // delay mode decode, registered to keep outputs glitch free
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         DLY_MODE       <= `SRA_DLY_RST;
         DLY_FINE_EN    <= 1'b0;
         DLY_LOW_JITTER <= 1'b0;
         AUTO_ADJ_EN    <= 1'b0;
      end else begin
         DLY_MODE       <= dly_mode;
         DLY_FINE_EN    <= (dly_mode == sra_pkg::SRA_DLY_FINE) ||
                           (dly_mode == sra_pkg::SRA_DLY_FINE_LJ); // see RL11
         DLY_LOW_JITTER <= (dly_mode == sra_pkg::SRA_DLY_FINE_LJ);
         AUTO_ADJ_EN    <= auto_en;
      end
   end

   // ---------------------------------------------------------------
   // register read path; reserved bits and holes read zero
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      unique case (REG_ADDR)
         `SRA_ADDR_CTRL: next_rdata = {auto_en, 3'h0, neg_win, pos_win};
         `SRA_ADDR_STAT: next_rdata = {4'h0, status};          // see RL9
         `SRA_ADDR_DLY:  next_rdata = {5'h00, dly_mode};
         default:        next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RE) begin
         REG_RDATA <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_ctrl_write;
      REG_WE && REG_ADDR == `SRA_ADDR_CTRL;
   endsequence

   sequence s_auto_capture;
      sref_evt && auto_en;
   endsequence

   property p_offset_sum;
      auto_en ##1 auto_en |->
         PHASE_OFFSET == 4'($past(status) + $past(LOCAL_PHASE));
   endproperty
   a_offset_sum: assert property (p_offset_sum)                // see RL1
      else $error("offset is not captured plus local phase");

   property p_neg_ignore;
      s_auto_capture ##0 (phase != 4'h0) ##0
      ((sra_pkg::sra_period_h(DIV_SEL) - phase) <= {2'h0, neg_win})
         |=> status == 4'h0;
   endproperty
   a_neg_ignore: assert property (p_neg_ignore)                // see RL2
      else $error("hit in negative window was not ignored");

   property p_neg_field;
      s_ctrl_write |=> neg_win == $past(REG_WDATA[3:2]);
   endproperty
   a_neg_field: assert property (p_neg_field)                  // see RL4
      else $error("negative window field not stored");

   property p_pos_ignore;
      s_auto_capture ##0 (phase <= {2'h0, pos_win}) |=> status == 4'h0;
   endproperty
   a_pos_ignore: assert property (p_pos_ignore)                // see RL5
      else $error("hit in positive window was not ignored");

   property p_no_auto_hold;
      !auto_en |=> $stable(status);
   endproperty
   a_no_auto_hold: assert property (p_no_auto_hold)            // see RL6
      else $error("status moved with auto adjust off");

   property p_exact_capture;
      s_auto_capture ##0 (pos_win == 2'h0) ##0 (phase != 4'h0) ##0
      !in_win |=> status == $past(phase);
   endproperty
   a_exact_capture: assert property (p_exact_capture)          // see RL8
      else $error("off edge hit not applied with zero window");

   property p_status_read;
      REG_RE && REG_ADDR == `SRA_ADDR_STAT |=>
         REG_RDATA == {4'h0, $past(status)};
   endproperty
   a_status_read: assert property (p_status_read)              // see RL9
      else $error("status read mismatch");

   property p_zero_win_track;
      s_auto_capture ##0 (neg_win == 2'h0) ##0 (pos_win == 2'h0)
         |=> status == capt_phase;
   endproperty
   a_zero_win_track: assert property (p_zero_win_track)        // see RL10
      else $error("status differs from captured phase");

   property p_dly_decode;
      ##1 (DLY_FINE_EN == ($past(dly_mode) == 3'h2 ||
                           $past(dly_mode) == 3'h3)) &&
          (DLY_LOW_JITTER == ($past(dly_mode) == 3'h3));
   endproperty
   a_dly_decode: assert property (p_dly_decode)                // see RL11
      else $error("delay mode decode wrong");

endmodule : sra_align

// File: sim/sra_sysref_gen.sv
// sysref source model standing in for the system clock generator
`timescale 1ns/1ns

module sra_sysref_gen (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       fire,
   input  wire logic [3:0] lag,
   output logic            sysref
);
   logic [3:0] wait_cnt;
   logic       armed;
   logic [1:0] hold;

   // edge comes lag plus one cycles after a request, so prompt and slow both occur
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed <= 1'b0;
         wait_cnt <= 4'h0;
         hold <= 2'h0;
         sysref <= 1'b0;
      end else if (fire) begin
         armed <= 1'b1;
         wait_cnt <= lag;
      end else if (armed && wait_cnt == 4'h0) begin
         armed <= 1'b0;
         sysref <= 1'b1;
         hold <= 2'h2;
      end else if (armed) begin
         wait_cnt <= wait_cnt - 4'h1;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
         sysref <= (hold != 2'h1);  // level held two cycles, then low
      end
   end
endmodule : sra_sysref_gen

// File: sim/test_sra_align.sv
// self-checking bench for the sysref divider phase aligner
`timescale 1ns/1ns
`include "sra_cfg.svh"

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
   err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module test_sra_align;
   logic        clk, rst_b, we, re, sysref, fire, au;
   logic        auto_en, fine_en, low_jit;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, cw;
   logic [1:0]  smode, md, ng, ps;
   logic [2:0]  ds, div_sel, dly_mode;
   logic [3:0]  lp, lag, p, per, e_st, e_capt;
   logic [3:0]  phase_off, capt_ph, div_ph;
   logic [15:0] regs [4] = '{16'h010a, 16'h010b, 16'h0110, 16'h0111};
   int          err_count, check_count, i, t;

   sra_align i_sra_align (.CLK(clk), .RST_B(rst_b), .REG_WE(we),
      .REG_RE(re), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .SYSREF(sysref), .SYSREF_MODE(smode), .DIV_SEL(div_sel),
      .LOCAL_PHASE(lp), .PHASE_OFFSET(phase_off), .CAPT_PHASE(capt_ph),
      .DIV_PHASE(div_ph), .AUTO_ADJ_EN(auto_en), .DLY_MODE(dly_mode),
      .DLY_FINE_EN(fine_en), .DLY_LOW_JITTER(low_jit));

   sra_sysref_gen i_sra_sysref_gen (.clk(clk), .rst_b(rst_b), .fire(fire),
      .lag(lag), .sysref(sysref));

   // ------------------------------------------------------------
   // expectation helpers
   // ------------------------------------------------------------
   // divider period in half cycles
   function automatic logic [3:0] period(input logic [2:0] d);
      return (d == 3'h1) ? 4'h4 : (d == 3'h3) ? 4'h8 : 4'h2;
   endfunction : period

   // a capture inside either skew window applies phase zero
   function automatic logic [3:0] applied(input logic [3:0] ph, pr,
                                          input logic [1:0] n, s);
      if (ph <= {2'h0, s}) return 4'h0;
      if (ph != 4'h0 && pr - ph <= {2'h0, n}) return 4'h0;
      return ph;
   endfunction : applied

   // ------------------------------------------------------------
   // register port and closing tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr

   // read data lands one edge after the strobe
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1;
   endtask : rd

   task automatic results();
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst_b, we, re, fire, addr, wdata, smode, lp, lag} = '0;
      {err_count, check_count, e_st, e_capt} = '0;
      div_sel = 3'h1;
      void'($urandom(32'hbe956ba9));
      repeat (3) @(posedge clk);
      `CHK("reset outs", 20'h0, {rdata, phase_off, capt_ph, auto_en, dly_mode})
      rst_b <= 1'b1;
      // read-only and unmapped writes must leave everything at zero
      wr(`SRA_ADDR_STAT, 8'hff);
      wr(16'h0111, 8'hff);
      for (i = 0; i < 4; i++) begin
         rd(regs[i]);
         `CHK("reg reset", 8'h00, rdata)
      end
      // every delay mode code, reserved bits written random
      // fine step register lies outside; kept 0 to 16
      for (i = 0; i < 8; i++) begin
         cw = {5'($urandom), i[2:0]};
         wr(`SRA_ADDR_DLY, cw);
         @(posedge clk);
         #1;
         `CHK("dly mode", i[2:0], dly_mode)
         `CHK("fine en", (i == 2 || i == 3), fine_en)
         `CHK("low jitter", (i == 3), low_jit)
         rd(`SRA_ADDR_DLY);
         `CHK("dly read", {5'h0, i[2:0]}, rdata)
      end
      // divide by one: the phase counter must sit at zero
      @(posedge clk);
      div_sel <= 3'h0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("div1 phase", 4'h0, div_ph)
      // divider stays at div2 first, then div4, never shrinking mid-run
      for (t = 0; t < 60; t++) begin
         ds = (t < 30) ? 3'h1 : 3'h3;
         ps = 2'($urandom % ds);
         ng = 2'($urandom % (ds - ps));
         if (t == 30) {ng, ps} = 4'h8;
         if (t == 31) {ng, ps} = 4'h2;
         if (t == 32) {ng, ps} = 4'h0;
         au = (t >= 30 && t < 33) ? 1'b1 : 1'($urandom);
         cw = {au, 3'($urandom), ng, ps};
         @(posedge clk);
         smode <= 2'h0;
         div_sel <= ds;
         lp <= 4'($urandom);
         wr(`SRA_ADDR_CTRL, cw);
         @(posedge clk);
         #1;
         `CHK("auto copy", au, auto_en)
         md = 2'($urandom);
         @(posedge clk);
         smode <= md;
         fire <= 1'b1;
         lag <= 4'($urandom % 6);
         @(posedge clk);
         fire <= 1'b0;
         for (i = 0; i < 20 && sysref !== 1'b1; i++) begin
            @(posedge clk);
            #1;
         end
         if (sysref !== 1'b1) begin
            err_count++;
            results();
         end
         p = div_ph;
         per = period(ds);
         @(posedge clk);
         #1;
         if (md != 2'h0) begin
            e_capt = p;
            if (au) e_st = applied(p, per, ng, ps);
         end
         `CHK("capt phase", e_capt, capt_ph)
         `CHK("phase step", 4'((p + 4'h2) % per), div_ph)
         @(posedge clk);
         #1;
         `CHK("offset", au ? 4'(e_st + lp) : lp, phase_off)
         rd(`SRA_ADDR_STAT);
         `CHK("status", {4'h0, e_st}, rdata)
         rd(`SRA_ADDR_CTRL);
         `CHK("ctrl read", cw & 8'h8f, rdata)
      end
      results();
   end
endmodule : test_sra_align
